// ---- shared/asr_defs.svh ----
// constants for the converter status and calibration register access block
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// control word fields
`define ASR_CTL_PWR_HI      9
`define ASR_CTL_PWR_LO      8
`define ASR_CTL_RDSEL_HI    7
`define ASR_CTL_RDSEL_LO    6
`define ASR_CTL_RANGE       5
`define ASR_CTL_CONV        4
`define ASR_CTL_CALKIND     3
`define ASR_CTL_GROUP_HI    2
`define ASR_CTL_GROUP_LO    1
`define ASR_CTL_CALSTART    0

// status word fields
`define ASR_ST_ZERO_HI      15
`define ASR_ST_ZERO_LO      10
`define ASR_ST_ONE_HI       7
`define ASR_ST_ONE_LO       6
`define ASR_ST_BUSY         4

// read targets
`define ASR_RDSEL_DATA      2'h0
`define ASR_RDSEL_COEF      2'h2
`define ASR_RDSEL_STATUS    2'h3

// coefficient groups
`define ASR_GRP_ALL         2'h0
`define ASR_GRP_GAIN_OFS    2'h1
`define ASR_GRP_OFS         2'h2
`define ASR_GRP_GAIN        2'h3

// coefficient storage indices
`define ASR_IDX_GAIN        4'h0
`define ASR_IDX_OFS         4'h1
`define ASR_IDX_DAC0        4'h2
`define ASR_IDX_LAST        4'h9

// reset values
`define ASR_CTL_RESET       16'h0000
`define ASR_COEF_RESET      14'h0000

// timing
`define ASR_CLK_NS          40
`define ASR_CONV_NS         4000
`define ASR_CONV_CYC        ((`ASR_CONV_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_CAL_NS          40000
`define ASR_CAL_CYC         ((`ASR_CAL_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

`endif

// ---- shared/asr_pkg.sv ----
// types for the converter status and calibration register access block
package asr_pkg;

  typedef logic [15:0] asr_word_t;
  typedef logic [13:0] asr_coef_t;
  typedef logic [3:0]  asr_idx_t;

  typedef enum logic [1:0] {
    ASR_IDLE = 2'h0,
    ASR_CONV = 2'h1,
    ASR_CAL  = 2'h3
  } asr_state_e;

endpackage : asr_pkg

// ---- rtl/asr_sync.sv ----
// three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none

module asr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] clean
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_clean;

  always_comb
  begin
    next_clean = clean;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (stage2[i] == stage3[i])
      begin
        next_clean[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      clean  <= '0;
    end
    else
    begin
      stage1 <= raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
      clean  <= next_clean;
    end
  end

endmodule : asr_sync

`default_nettype wire

// ---- rtl/asr_regs.sv ----
// status word, control word and calibration coefficient access over the parallel port
// How it works
// - sixteen-bit status word is read only; coefficient writes never change it
// - control write with both read-select bits set makes reads return status
// - power-up clears every status state bit
// - status bits 15 to 10 always read zero
// - status bits 7 and 6 always read one
// - status bits 9 and 8 show the power setting
// - status bit 5 shows input range, zero unipolar, one bipolar
// - status bit 4 is one during conversion or calibration
// - status bit 3 shows calibration kind, zero self, one system
// - status bit 0 is one while a calibration runs
// - status bits 2 and 1 echo the coefficient group selection
// - ten coefficient registers, host read/write, updated by calibration
// - group 00 all ten, 01 gain then offset, 10 offset, 11 gain
// - pointer resets on group-setting control write and after sequence end
// - reset pointer is gain, except offset-only group which starts at offset
// - pointer advances after each full access; in byte mode after high byte
// - abandoned sequences are recovered by the next control write
// - coefficient reads return two leading zero bits
// - offset and gain hold fourteen data bits under two fixed zeros
// - control write without calibration start treats group bits as address
// - control bits 7 and 6 choose the read target
`timescale 1ns/1ns
`default_nettype none
`include "asr_defs.svh"

module asr_regs #(
  parameter int unsigned CONV_CYC = `ASR_CONV_CYC,
  parameter int unsigned CAL_CYC  = `ASR_CAL_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        addr_ctl,
  input  wire logic        high_byte_select,
  input  wire logic        byte_mode,
  input  wire logic [15:0] data_in,
  input  wire logic [11:0] conv_result,
  input  wire logic [13:0] cal_coef_value,
  output logic      [15:0] data_out,
  output logic             data_oe,
  output logic             busy,
  output logic             cal_active
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  logic [4:0] pins_clean;
  logic       rd_lvl;
  logic       wr_lvl;
  logic       hbs_lvl;
  logic       ctl_lvl;
  logic       byte_lvl;

  asr_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .raw_in  ({~(chip_select_n | read_n), ~(chip_select_n | write_n),
               high_byte_select, addr_ctl, byte_mode}),
    .clean   (pins_clean)
  );

  assign rd_lvl   = pins_clean[4];
  assign wr_lvl   = pins_clean[3];
  assign hbs_lvl  = pins_clean[2];
  assign ctl_lvl  = pins_clean[1];
  assign byte_lvl = pins_clean[0];

  logic rd_prev;
  logic wr_prev;
  logic rd_end;
  logic wr_end;

  // strobes act at their trailing edge, when data and byte select have settled
  assign rd_end = rd_prev & ~rd_lvl;
  assign wr_end = wr_prev & ~wr_lvl;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic asr_pkg::asr_idx_t first_idx(input logic [1:0] grp);
    first_idx = (grp == `ASR_GRP_OFS) ? `ASR_IDX_OFS : `ASR_IDX_GAIN;
  endfunction : first_idx

  function automatic logic is_last(input logic [1:0] grp, input asr_pkg::asr_idx_t idx);
    unique case (grp)
      `ASR_GRP_ALL:      is_last = (idx == `ASR_IDX_LAST);
      `ASR_GRP_GAIN_OFS: is_last = (idx == `ASR_IDX_OFS);
      default:           is_last = 1'b1;
    endcase
  endfunction : is_last

  // ****************************************************************
  // control, sequencing and coefficient state
  // ****************************************************************
  asr_pkg::asr_word_t  ctl;
  asr_pkg::asr_word_t  next_ctl;
  asr_pkg::asr_state_e state;
  asr_pkg::asr_state_e next_state;
  logic [15:0]         timer;
  logic [15:0]         next_timer;
  asr_pkg::asr_idx_t   ptr;
  asr_pkg::asr_idx_t   next_ptr;
  logic [7:0]          low_hold;
  logic [7:0]          next_low_hold;
  asr_pkg::asr_coef_t  coef      [10];
  asr_pkg::asr_coef_t  next_coef [10];
  logic [15:0]         next_data_out;
  logic                next_data_oe;
  logic                ctl_wr;
  logic                coef_wr;
  logic                coef_rd;
  logic                access_done;
  logic [15:0]         status_word;
  logic [15:0]         coef_word;

  assign ctl_wr  = wr_end & ctl_lvl;
  assign coef_wr = wr_end & ~ctl_lvl;
  assign coef_rd = rd_end & (ctl[`ASR_CTL_RDSEL_HI:`ASR_CTL_RDSEL_LO] == `ASR_RDSEL_COEF);

  // in byte mode only the high byte completes a register access
  assign access_done = (coef_wr | coef_rd) & (~byte_lvl | hbs_lvl);

  assign coef_word = {2'h0, coef[ptr]};

  always_comb
  begin
    status_word = 16'h0000;
    status_word[`ASR_CTL_PWR_HI:`ASR_CTL_PWR_LO] =
      ctl[`ASR_CTL_PWR_HI:`ASR_CTL_PWR_LO];
    status_word[`ASR_ST_ONE_HI:`ASR_ST_ONE_LO] = 2'h3;
    status_word[`ASR_CTL_RANGE]   = ctl[`ASR_CTL_RANGE];
    status_word[`ASR_ST_BUSY]     = (state != asr_pkg::ASR_IDLE);
    status_word[`ASR_CTL_CALKIND] = ctl[`ASR_CTL_CALKIND];
    status_word[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO] =
      ctl[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO];
    status_word[`ASR_CTL_CALSTART] = (state == asr_pkg::ASR_CAL);
  end

  always_comb
  begin
    next_ctl      = ctl;
    next_state    = state;
    next_timer    = timer;
    next_ptr      = ptr;
    next_low_hold = low_hold;
    next_coef     = coef;

    // conversion and calibration sequencing
    unique case (state)
      asr_pkg::ASR_IDLE:
      begin
        if (ctl_wr && data_in[`ASR_CTL_CALSTART])
        begin
          next_state = asr_pkg::ASR_CAL;
          next_timer = 16'(CAL_CYC);
        end
        else if (ctl_wr && data_in[`ASR_CTL_CONV])
        begin
          next_state = asr_pkg::ASR_CONV;
          next_timer = 16'(CONV_CYC);
        end
      end
      asr_pkg::ASR_CONV,
      asr_pkg::ASR_CAL:
      begin
        next_timer = timer - 16'h0001;
        if (timer == 16'h0001)
        begin
          next_state = asr_pkg::ASR_IDLE;
          next_ctl[`ASR_CTL_CONV]     = 1'b0;
          next_ctl[`ASR_CTL_CALSTART] = 1'b0;
          if (state == asr_pkg::ASR_CAL)
          begin
            // calibration refreshes the coefficients it covers
            unique case (ctl[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO])
              `ASR_GRP_ALL:
                for (int i = 0; i < 10; i++)
                begin
                  next_coef[i] = cal_coef_value;
                end
              `ASR_GRP_GAIN_OFS:
              begin
                next_coef[`ASR_IDX_GAIN] = cal_coef_value;
                next_coef[`ASR_IDX_OFS]  = cal_coef_value;
              end
              `ASR_GRP_OFS:  next_coef[`ASR_IDX_OFS]  = cal_coef_value;
              `ASR_GRP_GAIN: next_coef[`ASR_IDX_GAIN] = cal_coef_value;
            endcase
          end
        end
      end
    endcase

    if (ctl_wr)
    begin
      // busy or start bits written while running are dropped; the running bits hold until the run ends
      next_ctl = data_in;
      // a run that ends in this same cycle still clears its start bit
      if (state != asr_pkg::ASR_IDLE)
      begin
        next_ctl[`ASR_CTL_CONV]     =
          (next_state != asr_pkg::ASR_IDLE) & ctl[`ASR_CTL_CONV];
        next_ctl[`ASR_CTL_CALSTART] =
          (next_state != asr_pkg::ASR_IDLE) & ctl[`ASR_CTL_CALSTART];
      end
      // every control write restarts the pointer, abandoning any sequence
      next_ptr = first_idx(data_in[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO]);
    end
    else if (coef_wr && state == asr_pkg::ASR_IDLE)
    begin
      if (byte_lvl && !hbs_lvl)
      begin
        next_low_hold = data_in[7:0];
      end
      else if (byte_lvl)
      begin
        next_coef[ptr] = {data_in[5:0], low_hold};
      end
      else
      begin
        next_coef[ptr] = data_in[13:0];
      end
    end

    if (access_done && !ctl_wr)
    begin
      if (is_last(ctl[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO], ptr))
      begin
        next_ptr = first_idx(ctl[`ASR_CTL_GROUP_HI:`ASR_CTL_GROUP_LO]);
      end
      else
      begin
        next_ptr = 4'(ptr + 4'h1);
      end
    end
  end

  // ****************************************************************
  // read data path
  // ****************************************************************
  always_comb
  begin
    next_data_oe  = rd_lvl;
    next_data_out = 16'h0000;
    if (rd_lvl)
    begin
      unique case (ctl[`ASR_CTL_RDSEL_HI:`ASR_CTL_RDSEL_LO])
        `ASR_RDSEL_STATUS: next_data_out = status_word;
        `ASR_RDSEL_COEF:   next_data_out = coef_word;
        default:           next_data_out = {4'h0, conv_result};
      endcase
      if (byte_lvl)
      begin
        next_data_out = hbs_lvl ? {8'h00, next_data_out[15:8]} : {8'h00, next_data_out[7:0]};
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctl        <= `ASR_CTL_RESET;
      state      <= asr_pkg::ASR_IDLE;
      timer      <= 16'h0000;
      ptr        <= `ASR_IDX_GAIN;
      low_hold   <= 8'h00;
      coef       <= '{default: `ASR_COEF_RESET};
      rd_prev    <= 1'b0;
      wr_prev    <= 1'b0;
      data_out   <= 16'h0000;
      data_oe    <= 1'b0;
      busy       <= 1'b0;
      cal_active <= 1'b0;
    end
    else
    begin
      ctl        <= next_ctl;
      state      <= next_state;
      timer      <= next_timer;
      ptr        <= next_ptr;
      low_hold   <= next_low_hold;
      coef       <= next_coef;
      rd_prev    <= rd_lvl;
      wr_prev    <= wr_lvl;
      data_out   <= next_data_out;
      data_oe    <= next_data_oe;
      busy       <= (next_state != asr_pkg::ASR_IDLE);
      cal_active <= (next_state == asr_pkg::ASR_CAL);
    end
  end

endmodule : asr_regs

`default_nettype wire

// ---- sim/asr_regs_sva.sv ----
// concurrent checks on the ports of the register access block
`timescale 1ns/1ns
`default_nettype none

module asr_regs_sva #(
  parameter int unsigned CONV_CYC = 100,
  parameter int unsigned CAL_CYC  = 1000
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        chip_select_n,
  input wire logic        read_n,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        busy,
  input wire logic        cal_active
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  logic [15:0] run;
  logic [15:0] next_run;

  // length of the current busy stretch; a stuck busy shows up here
  always_comb next_run = (sys_rst || !busy) ? 16'h0 : run + 16'h1;
  always_ff @(posedge mclk) run <= next_run;

  a_reset_clears_out: assert property ($fell(sys_rst) |->
    !busy && !cal_active && !data_oe && data_out == 16'h0) else $error("outputs set after reset");
  a_idle_out_zero: assert property (!data_oe |-> data_out == 16'h0)
    else $error("read data driven outside a read");
  a_cal_in_busy: assert property (cal_active |-> busy)
    else $error("calibration running without busy");
  a_top_bits_zero: assert property (data_oe |-> data_out[15:14] == 2'b00)
    else $error("top read bits not zero");
  a_oe_from_read: assert property ($rose(data_oe) |->
    $past(chip_select_n, 3) == 1'b0 && $past(read_n, 3) == 1'b0)
    else $error("read enable without read strobe");
  a_oe_ends: assert property ($rose(read_n) |-> ##[1:8] !data_oe)
    else $error("read enable outlives strobe");
  a_busy_bounded: assert property (run <= 16'(CAL_CYC + CONV_CYC + 8))
    else $error("busy held too long");
  a_read_stable: assert property (data_oe && $past(data_oe) && !busy && !$past(busy)
    |-> $stable(data_out)) else $error("read data moved during a read");
endmodule : asr_regs_sva

bind asr_regs asr_regs_sva #(.CONV_CYC(CONV_CYC), .CAL_CYC(CAL_CYC)) u_sva (
  .mclk(mclk), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .read_n(read_n),
  .data_out(data_out), .data_oe(data_oe), .busy(busy), .cal_active(cal_active));

`default_nettype wire

// ---- sim/asr_host.sv ----
// host processor model driving the parallel port pins
`timescale 1ns/1ns
`default_nettype none

module asr_host (
  input  wire logic        mclk,
  output logic             chip_select_n,
  output logic             read_n,
  output logic             write_n,
  output logic             addr_ctl,
  output logic             high_byte_select,
  output logic             byte_mode,
  output logic      [15:0] data_in
);
  // ****
  // bus cycles
  // ****
  initial
  begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    addr_ctl = 1'b0;
    high_byte_select = 1'b0;
    byte_mode = 1'b0;
    data_in = 16'h5a5a;
  end

  // 8 clocks of strobe and 8 of gap: the pins are synchronised, so the
  // trailing edge is only acted on several clocks later
  task automatic cyc(input logic rd, input logic ctl, input logic hb, input logic bm,
                     input logic [15:0] d);
    @(posedge mclk);
    chip_select_n <= 1'b0;
    read_n <= ~rd;
    write_n <= rd;
    addr_ctl <= ctl;
    high_byte_select <= hb;
    byte_mode <= bm;
    data_in <= d;
    repeat (8) @(posedge mclk);
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
    write_n <= 1'b1;
    repeat (8) @(posedge mclk);
    data_in <= ~d; // released bus keeps no stale value
  endtask : cyc

  task automatic bytes(input logic rd, input logic [13:0] v);
    cyc(rd, 1'b0, 1'b0, 1'b1, {8'h00, v[7:0]});
    cyc(rd, 1'b0, 1'b1, 1'b1, {10'h000, v[13:8]});
  endtask : bytes
endmodule : asr_host

`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the status and coefficient register block
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic             mclk;
  logic             sys_rst;
  logic [11:0]      conv_result;
  logic [13:0]      cal_coef_value;
  wire logic        chip_select_n, read_n, write_n, addr_ctl, high_byte_select, byte_mode;
  wire logic        data_oe, busy, cal_active;
  wire logic [15:0] data_in, data_out;
  int               bad_count, n_compared, cycles;
  logic [31:0]      lfsr;
  logic [15:0]      exp_q[$], msk_q[$];
  logic [13:0]      v[10];
  logic             oe_q, oe_q2;
  logic [15:0]      c;

  // ****
  // clock, parts
  // ****
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  asr_host host (.mclk(mclk), .chip_select_n(chip_select_n), .read_n(read_n),
    .write_n(write_n), .addr_ctl(addr_ctl), .high_byte_select(high_byte_select),
    .byte_mode(byte_mode), .data_in(data_in));
  asr_regs #(.CONV_CYC(30), .CAL_CYC(60)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .addr_ctl(addr_ctl),
    .high_byte_select(high_byte_select), .byte_mode(byte_mode), .data_in(data_in),
    .conv_result(conv_result), .cal_coef_value(cal_coef_value), .data_out(data_out),
    .data_oe(data_oe), .busy(busy), .cal_active(cal_active));

  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic ctl(input logic [15:0] w);
    host.cyc(1'b0, 1'b1, 1'b0, 1'b0, w);
  endtask : ctl

  task automatic rd(input logic hb, input logic bm, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host.cyc(1'b1, 1'b0, hb, bm, 16'h0);
  endtask : rd

  task automatic wait_idle();
    repeat (200) if (busy === 1'b1) @(posedge mclk);
    cmp("busy", 16'h0, {15'h0, busy});
  endtask : wait_idle

  task automatic stop_test();
    cmp("unread", 16'h0, 16'(exp_q.size()));
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // read data taken on the second cycle of the read enable
  always @(posedge mclk)
  begin
    oe_q <= data_oe;
    oe_q2 <= oe_q;
    cycles <= cycles + 1;
    if (data_oe === 1'b1 && oe_q === 1'b1 && !oe_q2 && exp_q.size() > 0)
      cmp("read data", exp_q.pop_front(), data_out & msk_q.pop_front());
    if (cycles == 4000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ****
  // scenarios
  // ****
  initial
  begin
    sys_rst = 1'b1;
    lfsr = 32'h4a0567d0;
    conv_result = 12'h0;
    cal_coef_value = 14'h0;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    oe_q = 1'b0;
    oe_q2 = 1'b0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    ctl(16'h00c0);
    rd(1'b0, 1'b0, 16'h00c0, 16'hffff);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      c = (lfsr[15:0] & 16'h032e) | 16'h00c0;
      ctl(c);
      host.cyc(1'b0, 1'b0, 1'b0, 1'b0, lfsr[31:16]);
      rd(1'b0, 1'b0, c, 16'hffff);
    end
    ctl(16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      lfsr = lfsr_next(lfsr);
      v[i] = lfsr[13:0];
      host.cyc(1'b0, 1'b0, 1'b0, 1'b0, lfsr[15:0]);
    end
    ctl(16'h0080);
    for (int i = 0; i < 14; i++)
    begin
      if (i == 13)
        ctl(16'h0080); // abort after thirteen reads
      rd(1'b0, 1'b0, {2'b00, v[i == 13 ? 0 : i % 10]}, 16'hffff);
    end
    for (int g = 1; g < 4; g++)
    begin
      ctl(16'h0080 | 16'(g << 1));
      for (int k = 0; k < 3; k++)
        rd(1'b0, 1'b0, {2'b00, v[g == 1 ? k % 2 : (g == 2 ? 1 : 0)]}, 16'hffff);
    end
    lfsr = lfsr_next(lfsr);
    ctl(16'h0006);
    host.bytes(1'b0, lfsr[13:0]);
    ctl(16'h0086);
    for (int k = 0; k < 3; k++)
      rd(k[0], 1'b1, 16'(k[0] ? {2'b00, lfsr[13:8]} : lfsr[7:0]), 16'h00ff);
    rd(1'b0, 1'b0, {2'b00, lfsr[13:0]}, 16'hffff);
    for (int k = 0; k < 2; k++)
    begin
      lfsr = lfsr_next(lfsr);
      cal_coef_value <= lfsr[13:0];
      conv_result <= lfsr[27:16];
      c = 16'h00c7 | 16'(k << 3);
      ctl(c);
      rd(1'b0, 1'b0, c | 16'h0010, 16'hffff);
      cmp("cal_active", 16'h1, {15'h0, cal_active});
      wait_idle();
      rd(1'b0, 1'b0, c & 16'hfffe, 16'hffff);
      ctl(16'h0086);
      rd(1'b0, 1'b0, {2'b00, lfsr[13:0]}, 16'hffff);
    end
    // conversion with the data target selected; a coefficient write while busy is refused
    ctl(16'h0016);
    host.cyc(1'b0, 1'b0, 1'b0, 1'b0, ~lfsr[15:0]);
    cmp("busy", 16'h1, {15'h0, busy});
    cmp("cal_active", 16'h0, {15'h0, cal_active});
    wait_idle();
    rd(1'b0, 1'b0, {4'h0, conv_result}, 16'hffff);
    ctl(16'h0086);
    rd(1'b0, 1'b0, {2'b00, lfsr[13:0]}, 16'hffff);
    ctl(16'h00d0);
    rd(1'b0, 1'b0, 16'h00d0, 16'hffff);
    wait_idle();
    rd(1'b0, 1'b0, 16'h00c0, 16'hffff);
    // second reset while idle: control, pointer and coefficients all return to zero
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(1'b0, 1'b0, {4'h0, conv_result}, 16'hffff);
    ctl(16'h0080);
    rd(1'b0, 1'b0, 16'h0000, 16'hffff);
    repeat (10) @(posedge mclk);
    stop_test();
  end
endmodule : tb

`default_nettype wire
